// file: rtl/adc_input_mux_control.sv
// Control logic of a delta-sigma converter front end: serial port, register
// file, input multiplexer sequencing, monitors and conversion control.
// Assumes the serial pins come from another domain and are synchronised here;
// analog switches and the modulator sit outside and follow these outputs.
`timescale 1ns/10ps
module adc_input_mux_control #(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter int BBM_CYCLES    = adc_mux_pkg::BBM_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // Serial port pins
    input  wire logic        cs_n_i,
    input  wire logic        sclk_i,
    input  wire logic        din_i,
    output logic             data_out_ready_o,
    output logic             data_out_ready_oe_o,
    input  wire logic        start_pin_i,
    // Modulator interface
    input  wire logic [15:0] adc_data_i,
    input  wire logic        adc_valid_i,
    output logic             conv_run_o,
    // Multiplexer switches
    output logic [3:0]       pos_input_select_o,
    output logic [3:0]       neg_input_select_o,
    output logic             mux_connect_o,
    output logic             mid_supply_tie_o,
    output logic             temp_sense_o,
    output logic             avdd_quarter_o,
    output logic             dvdd_quarter_o,
    output logic             burnout_o,
    output logic [6:0]       sensor_bias_voltage_o,
    output logic [3:0]       excite1_route_o,
    output logic [3:0]       excite2_route_o,
    output logic [3:0]       gpio_on_analog_o,
    // Amplifier, filter and clock
    output logic [2:0]       gain_o,
    output logic             gain_amplifier_bypass_o,
    output logic [3:0]       data_rate_o,
    output logic             low_latency_o,
    output logic             reject_50_o,
    output logic             reject_60_o,
    output logic             clk_ext_sel_o
);
    // ========================================================================
    // Elaboration checks
    // ========================================================================
    if (BBM_CYCLES < 1 || BBM_CYCLES > 7) begin : g_chk
        $error("BBM_CYCLES must lie in 1..7");
    end

    typedef enum logic [1:0] {
        ST_CMD   = 2'b00,
        ST_WDATA = 2'b01,
        ST_READ  = 2'b10
    } spi_state_type;

    // ========================================================================
    // Helper functions
    // ========================================================================
    // Input code legal for this variant; common input counts too.
    function automatic logic input_ok(input logic [3:0] code);
        logic [3:0] top;
        top = LARGE_VARIANT ? adc_mux_pkg::MAX_LARGE : adc_mux_pkg::MAX_SMALL;
        input_ok = (code <= top) || (code == adc_mux_pkg::CODE_COMMON);
    endfunction

    // Line rejection: rate codes 0..2 are 2.5/5/10, 3=16.6, 4=20, 5=50, 6=60.
    function automatic logic [1:0] rejects(input logic [3:0] r,
                                           input logic ll);
        logic [1:0] res;
        res = 2'b00;
        if (r <= 4'h2) res = 2'b11;
        else if (r == 4'h3 || r == 4'h5) res = 2'b01;
        else if (r == 4'h6) res = 2'b10;
        else if (r == 4'h4) res = ll ? 2'b11 : 2'b10;
        rejects = res;
    endfunction

    // CRC-8 over the 16-bit result, MSB first.
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ d[i]) c = {c[6:0], 1'b0} ^ adc_mux_pkg::CRC_POLY;
            else c = {c[6:0], 1'b0};
        end
        crc8 = c;
    endfunction

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    // Index 0 is the metastable stage and only index 1 reads it.
    logic [2:0] sclk_s_q;
    logic [1:0] cs_s_q;
    logic [1:0] din_s_q;
    logic [2:0] start_s_q;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sclk_s_q  <= 3'h0;
            cs_s_q    <= 2'h3;
            din_s_q   <= 2'h0;
            start_s_q <= 3'h0;
        end else begin
            sclk_s_q  <= {sclk_s_q[1:0], sclk_i};
            cs_s_q    <= {cs_s_q[0], cs_n_i};
            din_s_q   <= {din_s_q[0], din_i};
            start_s_q <= {start_s_q[1:0], start_pin_i};
        end
    end

    logic sel_active;
    logic sclk_rise;
    logic sclk_fall;
    logic start_rise;
    assign sel_active = ~cs_s_q[1];
    assign sclk_rise  = sel_active & sclk_s_q[1] & ~sclk_s_q[2];
    assign sclk_fall  = sel_active & ~sclk_s_q[1] & sclk_s_q[2];
    assign start_rise = start_s_q[1] & ~start_s_q[2];

    // ========================================================================
    // Serial receiver and command decoder
    // ========================================================================
    // Mode 1 framing: host drives on rising edges, device samples on falling.
    logic [6:0]    rx_q;
    logic [2:0]    bit_cnt_q;
    logic          byte_done;
    logic [7:0]    rx_byte;
    spi_state_type state_q;
    logic [4:0]    addr_q;
    logic [23:0]   tx_q;
    logic [4:0]    tx_cnt_q;
    logic          wr_en;
    logic          cmd_start;
    logic          cmd_stop;
    logic          cmd_rdata;
    logic          cmd_rreg;
    logic [7:0]    rd_byte;

    assign byte_done = sclk_fall & (bit_cnt_q == 3'h7);
    assign rx_byte   = {rx_q, din_s_q[1]};
    assign wr_en     = byte_done & (state_q == ST_WDATA);
    assign cmd_start = byte_done & (state_q == ST_CMD) &
                       (rx_byte == adc_mux_pkg::CMD_START);
    assign cmd_stop  = byte_done & (state_q == ST_CMD) &
                       (rx_byte == adc_mux_pkg::CMD_STOP);
    assign cmd_rdata = byte_done & (state_q == ST_CMD) &
                       (rx_byte == adc_mux_pkg::CMD_RDATA);
    assign cmd_rreg  = byte_done & (state_q == ST_CMD) &
                       (rx_byte[7:5] == adc_mux_pkg::CMD_READ_OP);

    // Bit counter and shift register; chip select high realigns framing.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !sel_active) begin
            rx_q      <= 7'h00;
            bit_cnt_q <= 3'h0;
        end else if (sclk_fall) begin
            rx_q      <= rx_byte[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    logic [7:0]  sel_pend_q;
    logic [15:0] data_q;
    logic [7:0]  crc_q;
    logic        ready_q;
    logic        crc_en_q;

    // Transaction state; input bytes during a read-out are ignored.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !sel_active) begin
            state_q  <= ST_CMD;
            addr_q   <= 5'h00;
            tx_q     <= 24'h000000;
            tx_cnt_q <= 5'h00;
        end else begin
            case (state_q)
                ST_CMD: begin
                    if (byte_done) begin
                        addr_q <= rx_byte[4:0];
                        if (rx_byte[7:5] == adc_mux_pkg::CMD_WRITE_OP) begin
                            state_q <= ST_WDATA;
                        end else if (cmd_rreg) begin
                            tx_q     <= {rd_byte, 16'h0000};
                            tx_cnt_q <= adc_mux_pkg::LEN_BYTE;
                            state_q  <= ST_READ;
                        end else if (cmd_rdata) begin
                            tx_q     <= {data_q, crc_q};
                            tx_cnt_q <= crc_en_q ? adc_mux_pkg::LEN_DATA_CRC
                                                 : adc_mux_pkg::LEN_DATA;
                            state_q  <= ST_READ;
                        end
                    end
                end
                ST_WDATA: begin
                    if (byte_done) state_q <= ST_CMD;
                end
                ST_READ: begin
                    if (sclk_rise) tx_q <= {tx_q[22:0], 1'b0};
                    if (sclk_fall) begin
                        tx_cnt_q <= tx_cnt_q - 5'h01;
                        if (tx_cnt_q == 5'h01) state_q <= ST_CMD;
                    end
                end
                default: state_q <= ST_CMD;
            endcase
        end
    end

    // Combined pin: data bit while reading, otherwise the ready flag (low).
    logic dout_q;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dout_q <= 1'b1;
        end else if (state_q == ST_READ) begin
            if (sclk_rise) dout_q <= tx_q[23];
        end else begin
            dout_q <= ~ready_q;
        end
    end
    // Released while chip select is high so the pin can be shared.
    assign data_out_ready_o    = dout_q;
    assign data_out_ready_oe_o = sel_active;

    // ========================================================================
    // Register file
    // ========================================================================
    logic [7:0] gain_q;
    logic [7:0] rate_q;
    logic [7:0] excite_q;
    logic [6:0] bias_q;
    logic [4:0] sysmon_q;
    logic [3:0] gpio_q;
    logic [7:0] sel_act_q;
    logic [2:0] bbm_cnt_q;
    logic       wr_d;

    assign wr_d = wr_en;

    // Writes land on the last falling edge of the data byte; illegal codes
    // (reserved amplifier modes, rates past the top) leave the field alone.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sel_pend_q <= adc_mux_pkg::RST_INPUT_SELECT;
            gain_q     <= adc_mux_pkg::RST_GAIN;
            rate_q     <= adc_mux_pkg::RST_RATE;
            excite_q   <= adc_mux_pkg::RST_EXCITE;
            bias_q     <= 7'h00;
            sysmon_q   <= 5'h00;
            gpio_q     <= 4'h0;
        end else if (wr_d) begin
            case (addr_q)
                adc_mux_pkg::REG_INPUT_SELECT: sel_pend_q <= rx_byte;
                adc_mux_pkg::REG_GAIN: begin
                    if (rx_byte[4:3] <= adc_mux_pkg::PGA_ON) begin
                        gain_q <= {3'h0, rx_byte[4:0]};
                    end
                end
                adc_mux_pkg::REG_RATE: begin
                    if (rx_byte[3:0] <= adc_mux_pkg::RATE_MAX) begin
                        rate_q <= {1'b0, rx_byte[6:0]};
                    end
                end
                adc_mux_pkg::REG_EXCITE: excite_q <= rx_byte;
                adc_mux_pkg::REG_BIAS:   bias_q   <= rx_byte[6:0];
                adc_mux_pkg::REG_SYSMON: sysmon_q <= rx_byte[4:0];
                adc_mux_pkg::REG_GPIO:   gpio_q   <= rx_byte[3:0];
                default: ;
            endcase
        end
    end

    // Read-back; unmapped offsets return zero.
    always_comb begin
        case (rx_byte[4:0])
            adc_mux_pkg::REG_STATUS:
                rd_byte = {5'h00, crc_en_q, bbm_cnt_q != 3'h0, ready_q};
            adc_mux_pkg::REG_INPUT_SELECT: rd_byte = sel_pend_q;
            adc_mux_pkg::REG_GAIN:         rd_byte = gain_q;
            adc_mux_pkg::REG_RATE:         rd_byte = rate_q;
            adc_mux_pkg::REG_EXCITE:       rd_byte = excite_q;
            adc_mux_pkg::REG_BIAS:         rd_byte = {1'b0, bias_q};
            adc_mux_pkg::REG_SYSMON:       rd_byte = {3'h0, sysmon_q};
            adc_mux_pkg::REG_GPIO:         rd_byte = {4'h0, gpio_q};
            default:                       rd_byte = 8'h00;
        endcase
    end
    assign crc_en_q = sysmon_q[4];

    // ========================================================================
    // Break-before-make sequencer
    // ========================================================================
    // The staged selection only reaches the switches after the open window,
    // so two inputs can never be momentarily shorted together.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sel_act_q <= adc_mux_pkg::RST_INPUT_SELECT;
            bbm_cnt_q <= 3'h0;
        end else if (bbm_cnt_q != 3'h0) begin
            bbm_cnt_q <= bbm_cnt_q - 3'h1;
            if (bbm_cnt_q == 3'h1) sel_act_q <= sel_pend_q;
        end else if (sel_pend_q != sel_act_q) begin
            bbm_cnt_q <= 3'(BBM_CYCLES);
        end
    end

    logic bbm_busy;
    logic sel_legal;
    assign bbm_busy  = bbm_cnt_q != 3'h0;
    // Common input passes the same legality test as the rest.
    assign sel_legal = input_ok(sel_act_q[7:4]) & input_ok(sel_act_q[3:0]);

    // Switch controls; any monitor takes the pins off the amplifier.
    assign pos_input_select_o = sel_act_q[7:4];
    assign neg_input_select_o = sel_act_q[3:0];
    assign mux_connect_o  = ~bbm_busy & sel_legal &
                            (sysmon_q[2:0] == adc_mux_pkg::MON_NONE);
    assign mid_supply_tie_o = bbm_busy |
                              (sysmon_q[2:0] == adc_mux_pkg::MON_SHORT);
    assign temp_sense_o   = sysmon_q[2:0] == adc_mux_pkg::MON_TEMP;
    assign avdd_quarter_o = sysmon_q[2:0] == adc_mux_pkg::MON_AVDD;
    assign dvdd_quarter_o = sysmon_q[2:0] == adc_mux_pkg::MON_DVDD;
    assign burnout_o      = sysmon_q[3] & mux_connect_o;
    assign sensor_bias_voltage_o = bias_q;
    // Any legal pin code routes a source; others switch it off.
    assign excite1_route_o = input_ok(excite_q[3:0]) ? excite_q[3:0]
                                                     : adc_mux_pkg::CODE_OFF;
    assign excite2_route_o = input_ok(excite_q[7:4]) ? excite_q[7:4]
                                                     : adc_mux_pkg::CODE_OFF;
    assign gpio_on_analog_o = LARGE_VARIANT ? gpio_q : 4'h0;

    // Amplifier, filter and clock selections.
    assign gain_o = gain_q[2:0];
    assign gain_amplifier_bypass_o = gain_q[4:3] == adc_mux_pkg::PGA_BYPASS;
    assign data_rate_o   = rate_q[3:0];
    assign low_latency_o = rate_q[4];
    assign {reject_60_o, reject_50_o} = rejects(rate_q[3:0],
                                                rate_q[4]);
    assign clk_ext_sel_o = rate_q[6];

    // ========================================================================
    // Conversion control and result capture
    // ========================================================================
    logic running_q;
    logic accept;
    assign accept     = running_q & adc_valid_i & ~bbm_busy;
    assign conv_run_o = running_q;

    // Stop wins over a simultaneous start, so a stray pin edge cannot
    // override the host's explicit stop.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            running_q <= 1'b0;
        end else if (cmd_stop || (accept && rate_q[5])) begin
            running_q <= 1'b0;
        end else if (cmd_start || start_rise) begin
            running_q <= 1'b1;
        end
    end

    // A result arriving as read-out starts keeps the ready flag set.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            data_q  <= 16'h0000;
            crc_q   <= 8'h00;
            ready_q <= 1'b0;
        end else if (accept) begin
            data_q  <= adc_data_i;
            crc_q   <= crc8(adc_data_i);
            ready_q <= 1'b1;
        end else if (cmd_rdata) begin
            ready_q <= 1'b0;
        end
    end

    // ========================================================================
    // Assertions
    // ========================================================================
    property p_bbm_window;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!bbm_busy && sel_pend_q != sel_act_q) |=>
            (mid_supply_tie_o && !mux_connect_o) [*2] ##1 !bbm_busy;
    endproperty
    a_bbm_window: assert property (p_bbm_window)
        else $error("break window not two cycles");

    property p_sel_update;
        @(posedge clk_sys_i) disable iff (rst_i)
        bbm_cnt_q == 3'h1 |=> pos_input_select_o == $past(sel_pend_q[7:4]) &&
                              neg_input_select_o == $past(sel_pend_q[3:0]);
    endproperty
    a_sel_update: assert property (p_sel_update)
        else $error("selection not applied after window");

    property p_commit;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_en && addr_q == adc_mux_pkg::REG_INPUT_SELECT) |=>
            sel_pend_q == $past(rx_byte) ##1 bbm_busy || sel_pend_q == sel_act_q;
    endproperty
    a_commit: assert property (p_commit)
        else $error("selection write not committed");

    property p_short;
        @(posedge clk_sys_i) disable iff (rst_i)
        sysmon_q[2:0] == adc_mux_pkg::MON_SHORT |->
            mid_supply_tie_o && !mux_connect_o;
    endproperty
    a_short: assert property (p_short)
        else $error("offset short not applied");

    property p_burnout;
        @(posedge clk_sys_i) disable iff (rst_i)
        burnout_o |-> mux_connect_o && !bbm_busy;
    endproperty
    a_burnout: assert property (p_burnout)
        else $error("burn-out on unselected inputs");

    property p_single;
        @(posedge clk_sys_i) disable iff (rst_i)
        (accept && rate_q[5]) |=> !conv_run_o;
    endproperty
    a_single: assert property (p_single)
        else $error("single shot kept running");

    property p_ready_pin;
        @(posedge clk_sys_i) disable iff (rst_i)
        (accept && state_q != ST_READ) |=> ##1
            (!data_out_ready_o || state_q == ST_READ);
    endproperty
    a_ready_pin: assert property (p_ready_pin)
        else $error("ready not shown on pin");

    property p_start;
        @(posedge clk_sys_i) disable iff (rst_i)
        (cmd_start && !cmd_stop && !(accept && rate_q[5])) |=> conv_run_o;
    endproperty
    a_start: assert property (p_start)
        else $error("start command ignored");

    property p_reject;
        @(posedge clk_sys_i) disable iff (rst_i)
        data_rate_o == 4'h4 |-> reject_60_o && (reject_50_o == low_latency_o);
    endproperty
    a_reject: assert property (p_reject)
        else $error("wrong rejection at 20 SPS");
endmodule

// file: rtl/adc_mux_pkg.sv
// Package of constants for the converter front-end control block.
// Assumes a single system clock domain; the serial port is sampled, not clocked.
package adc_mux_pkg;
    // ========================================================================
    // Register offsets, one byte each
    // ========================================================================
    localparam logic [4:0] REG_STATUS       = 5'h01;
    localparam logic [4:0] REG_INPUT_SELECT = 5'h02;
    localparam logic [4:0] REG_GAIN         = 5'h03;
    localparam logic [4:0] REG_RATE         = 5'h04;
    localparam logic [4:0] REG_EXCITE       = 5'h07;
    localparam logic [4:0] REG_BIAS         = 5'h08;
    localparam logic [4:0] REG_SYSMON       = 5'h09;
    localparam logic [4:0] REG_GPIO         = 5'h0a;
    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [7:0] RST_INPUT_SELECT = 8'h01;
    localparam logic [7:0] RST_GAIN         = 8'h08;
    localparam logic [7:0] RST_RATE         = 8'h04;
    localparam logic [7:0] RST_EXCITE       = 8'hff;
    // ========================================================================
    // Serial commands
    // ========================================================================
    localparam logic [2:0] CMD_WRITE_OP = 3'h2;
    localparam logic [2:0] CMD_READ_OP  = 3'h1;
    localparam logic [7:0] CMD_START    = 8'h08;
    localparam logic [7:0] CMD_STOP     = 8'h0a;
    localparam logic [7:0] CMD_RDATA    = 8'h12;
    // ========================================================================
    // Field codes and timing
    // ========================================================================
    localparam logic [3:0] CODE_COMMON    = 4'hc;
    localparam logic [3:0] CODE_OFF       = 4'hf;
    localparam logic [3:0] MAX_LARGE      = 4'hb;
    localparam logic [3:0] MAX_SMALL      = 4'h5;
    localparam logic [3:0] RATE_MAX       = 4'hd;
    localparam logic [1:0] PGA_BYPASS     = 2'h0;
    localparam logic [1:0] PGA_ON         = 2'h1;
    localparam logic [2:0] MON_NONE       = 3'h0;
    localparam logic [2:0] MON_SHORT      = 3'h1;
    localparam logic [2:0] MON_TEMP       = 3'h2;
    localparam logic [2:0] MON_AVDD       = 3'h3;
    localparam logic [2:0] MON_DVDD       = 3'h4;
    localparam logic [7:0] CRC_POLY       = 8'h07;
    localparam int         BBM_CYCLES     = 2;
    localparam logic [4:0] LEN_DATA       = 5'd16;
    localparam logic [4:0] LEN_DATA_CRC   = 5'd24;
    localparam logic [4:0] LEN_BYTE       = 5'd8;
endpackage

// file: tb/spi_host_model.sv
// Host side of the serial port: chip select, link clock and data out.
// Assumes the device samples these pins with its own system clock.
`timescale 1ns/10ps
module spi_host_model (
    // Pins
    input  wire logic clk_sys_i,
    input  wire logic miso_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      mosi_o
);
    // ========================================================================
    // Frames
    // ========================================================================
    // The link clock idles low and runs only inside frames.
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b1;
    end
    // One byte, MSB first; eight system clocks per half period give 160 ns.
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(negedge clk_sys_i);
            sclk_o = 1'b1;
            mosi_o = tx[i];
            repeat (8) @(negedge clk_sys_i);
            rx[i] = miso_i;
            sclk_o = 1'b0;
            repeat (7) @(negedge clk_sys_i);
        end
    endtask
    task automatic on;
        @(negedge clk_sys_i);
        cs_n_o = 1'b0;
        repeat (4) @(negedge clk_sys_i);
    endtask
    // Data is flipped on release so a stale level is never mistaken for data.
    task automatic off;
        repeat (8) @(negedge clk_sys_i);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
    endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the converter front-end control block.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/10ps
module testbench;
    // ========================================================================
    // Pins and bench state
    // ========================================================================
    logic        clk_sys_i   = 1'b0;
    logic        rst_i       = 1'b1;
    logic        start_pin_i = 1'b0;
    logic        adc_valid_i = 1'b0;
    logic [15:0] adc_data_i  = 16'h0000;
    logic        cs_n, sclk, din, dout, oe, conn, tie, temp, avq, dvq, burn, run;
    logic [3:0]  pos, neg;
    logic [7:0]  rx;
    logic [15:0] dat;
    logic [6:0]  bias;
    logic [3:0]  ex1, ex2, gpio, rate;
    logic [7:0]  c;
    logic [2:0]  gain;
    logic        byp, ll, r50, r60, ext;
    int          n_mismatch, cmp_count, run_len, last_run, p, n;
    always #5 clk_sys_i = ~clk_sys_i;
    adc_input_mux_control adc_input_mux_control_inst (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .din_i(din), .data_out_ready_o(dout), .data_out_ready_oe_o(oe),
        .start_pin_i(start_pin_i), .adc_data_i(adc_data_i),
        .adc_valid_i(adc_valid_i), .conv_run_o(run),
        .pos_input_select_o(pos), .neg_input_select_o(neg),
        .mux_connect_o(conn), .mid_supply_tie_o(tie), .temp_sense_o(temp),
        .avdd_quarter_o(avq), .dvdd_quarter_o(dvq), .burnout_o(burn),
        .sensor_bias_voltage_o(bias), .excite1_route_o(ex1),
        .excite2_route_o(ex2), .gpio_on_analog_o(gpio), .gain_o(gain),
        .gain_amplifier_bypass_o(byp), .data_rate_o(rate),
        .low_latency_o(ll), .reject_50_o(r50), .reject_60_o(r60),
        .clk_ext_sel_o(ext));
    spi_host_model spi_host_model_inst (.clk_sys_i(clk_sys_i),
        .miso_i(dout), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(din));
    // Length of the last mid-supply tie, sampled where outputs are settled.
    always @(negedge clk_sys_i) begin
        if (tie === 1'b1) run_len = run_len + 1;
        else if (run_len != 0) begin
            last_run = run_len;
            run_len = 0;
        end
    end
    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Command byte, then nb bytes of v; received bytes shift into dat.
    task automatic frame(input logic [7:0] a, input logic [7:0] v,
                         input int nb);
        spi_host_model_inst.on();
        spi_host_model_inst.xbyte(a, rx);
        for (int k = 0; k < nb; k++) begin
            spi_host_model_inst.xbyte(v, rx);
            dat = {dat[7:0], rx};
        end
        spi_host_model_inst.off();
        repeat (40) @(negedge clk_sys_i);
    endtask
    task automatic close_out;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard, about five times the expected length of the run.
    initial begin
        #400000;
        n_mismatch++;
        close_out();
    end
    // ========================================================================
    // Tests
    // ========================================================================
    initial begin
        void'($urandom(65241));
        repeat (8) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        chk({pos, neg, conn, tie, oe}, {4'h0, 4'h1, 3'b100});
        // The first pass selects the common input.
        for (int i = 0; i < 4; i++) begin
            p = (i == 0) ? 12 : $urandom % 13;
            n = (i + p) % 13;
            last_run = 0;
            frame(8'h42, {p[3:0], n[3:0]}, 1);
            chk(last_run, 2);
            chk({pos, neg, conn}, {p[3:0], n[3:0], 1'b1});
            frame(8'h22, 8'h00, 1);
            chk(dat[7:0], {p[3:0], n[3:0]});
        end
        // Several commands inside one selection, as a three-wire host does.
        spi_host_model_inst.on();
        for (int k = 0; k < 2; k++) begin
            spi_host_model_inst.xbyte(8'h22, rx);
            spi_host_model_inst.xbyte(8'h00, rx);
            chk({rx, oe}, {p[3:0], n[3:0], 1'b1});
        end
        spi_host_model_inst.off();
        $display("Test select done");
        for (int m = 1; m < 5; m++) begin
            frame(8'h49, m[7:0], 1);
            chk({tie, conn, temp, avq, dvq},
                {m == 1, 1'b0, m == 2, m == 3, m == 4});
        end
        frame(8'h49, 8'h08, 1);
        chk(burn, 1'b1);
        $display("Test monitor done");
        frame(8'h43, 8'h0f, 1);
        chk({gain, byp}, {3'h7, 1'b0});
        frame(8'h43, 8'h00, 1);
        frame(8'h44, 8'h54, 1);
        frame(8'h47, 8'h3c, 1);
        frame(8'h48, 8'h7f, 1);
        frame(8'h4a, 8'h0a, 1);
        chk({gain, byp}, {3'h0, 1'b1});
        chk({rate, ll, r50, r60, ext}, {4'h4, 4'hf});
        chk({ex1, ex2, gpio, bias}, {12'hc3a, 7'h7f});
        // Single-shot at 16.6 SPS, then a rate code past the top is refused.
        frame(8'h44, 8'h23, 1);
        frame(8'h44, 8'h0f, 1);
        chk({rate, ll, r50, r60, ext}, {4'h3, 4'h4});
        $display("Test config done");
        frame(8'h08, 8'h00, 0);
        chk(run, 1'b1);
        adc_data_i = 16'($urandom);
        adc_valid_i = 1'b1;
        @(negedge clk_sys_i);
        adc_valid_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        chk({dout, run}, 2'b00);
        frame(8'h12, 8'h00, 2);
        chk(dat, adc_data_i);
        // With the check code on, the last two bytes are data low and code.
        frame(8'h49, 8'h10, 1);
        frame(8'h12, 8'h00, 3);
        c = 8'h00;
        for (int b = 15; b >= 0; b--) begin
            c = {c[6:0], 1'b0} ^
                ((c[7] ^ adc_data_i[b]) ? adc_mux_pkg::CRC_POLY : 8'h00);
        end
        chk(dat, {adc_data_i[7:0], c});
        start_pin_i = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        chk(run, 1'b1);
        frame(8'h0a, 8'h00, 0);
        chk(run, 1'b0);
        $display("Test conversion done");
        close_out();
    end
endmodule
